// [include/srwd_pkg.sv]
package srwd_pkg;

   // time base
   localparam int CLK_HZ          = 20_000_000;
   localparam int CNT_W           = 32;

   // reset release delay
   localparam int RST_DELAY_MS    = 200;
   localparam int RST_DELAY_CYC   = RST_DELAY_MS * (CLK_HZ / 1000);

   // manual reset to reset output, longest figure rounded down
   localparam int MR_DEL_NS       = 200;
   localparam int MR_DEL_CYC      = (MR_DEL_NS * (CLK_HZ / 1_000_000)) / 1000;

   // configuration probe
   localparam int INIT_US         = 381;
   localparam int INIT_CYC        = INIT_US * (CLK_HZ / 1_000_000);
   localparam int PROBE_DISCH_CYC = 20;
   localparam int PROBE_FAST_CYC  = 8;

   // watchdog timing
   localparam int WD_OPEN_MS      = 1600;
   localparam int WD_OPEN_CYC     = WD_OPEN_MS * (CLK_HZ / 1000);
   localparam int WD_PULL_MS      = 200;
   localparam int WD_PULL_CYC     = WD_PULL_MS * (CLK_HZ / 1000);
   localparam int SETTLE_US       = 150;
   localparam int SETTLE_CYC      = SETTLE_US * (CLK_HZ / 1_000_000);

   // capacitor formulas, slopes per nF
   localparam int CAP_STD_SLOPE_CENTI_MS = 323;  // 3.23 ms
   localparam int CAP_STD_OFS_US         = 381;  // 0.381 ms
   localparam int CAP_EXT_SLOPE_DECI_MS  = 774;  // 77.4 ms
   localparam int CAP_EXT_OFS_MS         = 55;
   localparam int CAP_DEF_NF             = 10;

   // sync vector bit positions
   localparam int SY_UV    = 0;
   localparam int SY_MR    = 1;
   localparam int SY_KICK  = 2;
   localparam int SY_STRAP = 3;
   localparam int SY_N     = 4;

   // reset values: every bit high, MR, kick and strap at idle and UV below threshold, so no false kick or strap edge follows reset
   localparam logic [SY_N-1:0] SYNC_RST = 4'hf;

   typedef enum logic [1:0] {
      CFG_OPEN   = 2'b00,
      CFG_PULLUP = 2'b01,
      CFG_CAP    = 2'b10
   } srwd_cfg_e;

   typedef enum logic [1:0] {
      RST_HOLD  = 2'b00,
      RST_DELAY = 2'b01,
      RST_OFF   = 2'b10
   } srwd_rst_e;

   typedef enum logic [1:0] {
      WD_OFF    = 2'b00,
      WD_SETTLE = 2'b01,
      WD_RUN    = 2'b10,
      WD_FAULT  = 2'b11
   } srwd_wd_e;

   typedef enum logic [1:0] {
      P_IDLE  = 2'b00,
      P_DISCH = 2'b01,
      P_SENSE = 2'b10
   } srwd_probe_e;

   function automatic longint cap_ticks(input int nf, input bit ext);
      if (ext)
         cap_ticks = longint'(nf) * CAP_EXT_SLOPE_DECI_MS * (CLK_HZ / 10_000)
                   + longint'(CAP_EXT_OFS_MS) * (CLK_HZ / 1000);
      else
         cap_ticks = longint'(nf) * CAP_STD_SLOPE_CENTI_MS * (CLK_HZ / 100_000)
                   + longint'(CAP_STD_OFS_US) * (CLK_HZ / 1_000_000);
   endfunction

endpackage

// [include/srwd_probe_if.sv]
`timescale 1ns/1ps
interface srwd_probe_if;
   import srwd_pkg::*;
   logic      start;
   logic      done;
   srwd_cfg_e cfg;
   modport ctrl  (output start, input  done, input  cfg);
   modport probe (input  start, output done, output cfg);
endinterface

// [logic/srwd_probe.sv]
`timescale 1ns/1ps
module srwd_probe
   import srwd_pkg::*;
#(
   parameter int INIT_TICKS = INIT_CYC
) (
   // clock and reset
   input  wire logic   sys_clk,
   input  wire logic   srst,
   // configuration pin
   input  wire logic   cfgPinI,
   output logic        cfgPinO,
   output logic        cfgPinOe,
   // control side
   srwd_probe_if.probe pif
);

   srwd_probe_e          st_r;
   logic [CNT_W-1:0]     cnt_r;
   logic                 pinA_r;
   logic                 pinS_r;
   logic                 seen_r;
   srwd_cfg_e            cls_r;
   logic                 done_r;

   wire lastTick  = (cnt_r == CNT_W'(INIT_TICKS - 1));
   wire dischEnd  = (cnt_r == CNT_W'(PROBE_DISCH_CYC - 1));
   wire fastRise  = (cnt_r < CNT_W'(PROBE_DISCH_CYC + PROBE_FAST_CYC));
   wire catchRise = (st_r == P_SENSE) && pinS_r && !seen_r;

   // pin only ever pulled low, to empty a capacitor before timing its charge
   assign cfgPinO  = 1'b0;
   assign cfgPinOe = (st_r == P_DISCH);
   assign pif.done = done_r;
   assign pif.cfg  = cls_r;

   always_ff @(posedge sys_clk) begin
      pinA_r <= cfgPinI;
      pinS_r <= pinA_r;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r   <= P_IDLE;
         cnt_r  <= '0;
         seen_r <= 1'b0;
         cls_r  <= CFG_OPEN;
         done_r <= 1'b0;
      end else if (pif.start) begin
         st_r   <= P_DISCH;
         cnt_r  <= '0;
         seen_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         case (st_r)
            P_IDLE: begin
               cnt_r <= '0;
            end
            P_DISCH: begin
               cnt_r <= cnt_r + 1'b1;
               if (dischEnd)
                  st_r <= P_SENSE;
            end
            P_SENSE: begin
               cnt_r <= cnt_r + 1'b1;
               if (catchRise) begin
                  seen_r <= 1'b1;
                  cls_r  <= fastRise ? CFG_PULLUP : CFG_CAP;
               end
               if (lastTick) begin
                  st_r   <= P_IDLE;
                  done_r <= 1'b1;
                  if (!seen_r && !catchRise)
                     cls_r <= CFG_OPEN;
               end
            end
            default: begin
               st_r <= P_IDLE;
            end
         endcase
      end
   end

endmodule // srwd_probe

// [logic/srwd_supervisor.sv]
// Functional notes
// - hold reset full delay after supply returns
// - undervoltage asserts reset while it lasts
// - manual reset low asserts reset quickly
// - release needs manual high and valid supply
// - probe config pin on every supply valid entry
// - probe sorts open, pull-up, capacitor
// - open 1600 ms, pull-up 200 ms timeouts
// - fixed timeouts same in both variants
// - variant picks capacitor timeout formula
// - ignore kicks 150 us after enabling
// - only falling kick edges serve watchdog
// - missing kick before timeout drives fault low
// - reset asserted disables watchdog, ignores kicks
// - strap low disables watchdog and fault
// - fault held release delay, then restart
// - reset asserted releases fault output
// - capacitor timeout formulas per variant
`timescale 1ns/1ps
module srwd_supervisor
   import srwd_pkg::*;
#(
   parameter int RST_TICKS     = RST_DELAY_CYC,
   parameter int INIT_TICKS    = INIT_CYC,
   parameter int WD_OPEN_TICKS = WD_OPEN_CYC,
   parameter int WD_PULL_TICKS = WD_PULL_CYC,
   parameter bit EXTENDED      = 1'b0,
   parameter int CAP_NF        = CAP_DEF_NF,
   parameter longint CAP_TICKS = cap_ticks(CAP_NF, EXTENDED)
) (
   // clock and reset
   input  wire logic  sys_clk,
   input  wire logic  srst,
   // supply comparator, high while below threshold
   input  wire logic  uvBelowThr,
   // partner pins
   input  wire logic  manualResetInN,
   input  wire logic  wdKickIn,
   input  wire logic  wdEnableStrap,
   // configuration pin
   input  wire logic  timeoutConfigPinI,
   output logic       timeoutConfigPinO,
   output logic       timeoutConfigPinOe,
   // open-drain outputs, enable high pulls low
   output logic       resetOutNO,
   output logic       resetOutNOe,
   output logic       wdFaultOutNO,
   output logic       wdFaultOutNOe,
   // status
   output srwd_cfg_e  cfgClass,
   output logic       probeDone
);

   logic [SY_N-1:0]   syA_r;
   logic [SY_N-1:0]   syS_r;
   logic              uvD_r;
   logic              kickD_r;
   logic              strapD_r;
   srwd_rst_e         rst_r;
   logic [CNT_W-1:0]  rstCnt_r;
   srwd_wd_e          wd_r;
   logic [CNT_W-1:0]  wdCnt_r;
   logic              settlePend_r;
   logic              start_r;
   logic [CNT_W-1:0]  tmoTicks;

   srwd_probe_if pif ();

   // two flops per pin before anything looks at it
   genvar gi;
   generate
      for (gi = 0; gi < SY_N; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               syA_r[gi] <= SYNC_RST[gi];
               syS_r[gi] <= SYNC_RST[gi];
            end else begin
               syA_r[gi] <= (gi == SY_UV)   ? uvBelowThr :
                            (gi == SY_MR)   ? manualResetInN :
                            (gi == SY_KICK) ? wdKickIn : wdEnableStrap;
               syS_r[gi] <= syA_r[gi];
            end
         end
      end
   endgenerate

   wire uvS    = syS_r[SY_UV];
   wire mrS    = syS_r[SY_MR];
   wire kickS  = syS_r[SY_KICK];
   wire strapS = syS_r[SY_STRAP];

   wire holdReq    = uvS | ~mrS;
   wire validEntry = uvD_r & ~uvS;
   wire kickFall   = kickD_r & ~kickS;
   wire strapRise  = strapS & ~strapD_r;
   wire rstDone    = (rstCnt_r == CNT_W'(RST_TICKS - 1));
   wire rstActive  = (rst_r != RST_OFF);
   wire wdAllowed  = !rstActive && strapS && pif.done;
   wire wdHit      = (wdCnt_r == tmoTicks - 1'b1);
   wire settleEnd  = (wdCnt_r == CNT_W'(SETTLE_CYC - 1));
   wire faultEnd   = (wdCnt_r == CNT_W'(RST_TICKS - 1));

   assign tmoTicks = (pif.cfg == CFG_OPEN)   ? CNT_W'(WD_OPEN_TICKS) :
                     (pif.cfg == CFG_PULLUP) ? CNT_W'(WD_PULL_TICKS) :
                                               CNT_W'(CAP_TICKS);

   assign pif.start          = start_r;
   assign resetOutNO         = 1'b0;
   assign resetOutNOe        = rstActive;
   assign wdFaultOutNO       = 1'b0;
   assign wdFaultOutNOe      = (wd_r == WD_FAULT) && !rstActive;
   assign cfgClass           = pif.cfg;
   assign probeDone          = pif.done;

   srwd_probe #(
      .INIT_TICKS (INIT_TICKS)
   ) u_probe (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .cfgPinI  (timeoutConfigPinI),
      .cfgPinO  (timeoutConfigPinO),
      .cfgPinOe (timeoutConfigPinOe),
      .pif      (pif.probe)
   );

   // uvD starts high so a supply already valid at reset triggers a probe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         uvD_r    <= 1'b1;
         kickD_r  <= 1'b1;
         strapD_r <= 1'b1;
         start_r  <= 1'b0;
      end else begin
         uvD_r    <= uvS;
         kickD_r  <= kickS;
         strapD_r <= strapS;
         start_r  <= validEntry;
      end
   end

   // release needs mr high and supply valid
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rst_r    <= RST_HOLD;
         rstCnt_r <= '0;
      end else begin
         case (rst_r)
            RST_HOLD: begin
               rstCnt_r <= '0;
               if (!holdReq)
                  rst_r <= RST_DELAY;
            end
            RST_DELAY: begin
               rstCnt_r <= rstCnt_r + 1'b1;
               if (holdReq)
                  rst_r <= RST_HOLD;
               else if (rstDone)
                  rst_r <= RST_OFF;
            end
            RST_OFF: begin
               rstCnt_r <= '0;
               if (holdReq)
                  rst_r <= RST_HOLD;
            end
            default: begin
               rst_r <= RST_HOLD;
            end
         endcase
      end
   end

   // settle pending, a new strap rise wins over the clear
   always_ff @(posedge sys_clk) begin
      if (srst)
         settlePend_r <= 1'b0;
      else if (strapRise)
         settlePend_r <= 1'b1;
      else if (wd_r == WD_SETTLE && settleEnd)
         settlePend_r <= 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (srst || !wdAllowed) begin
         wd_r    <= WD_OFF;
         wdCnt_r <= '0;
      end else begin
         case (wd_r)
            WD_OFF: begin
               wdCnt_r <= '0;
               // rise seen this edge has not reached the pending flag yet
               wd_r    <= (settlePend_r || strapRise) ? WD_SETTLE : WD_RUN;
            end
            WD_SETTLE: begin
               wdCnt_r <= wdCnt_r + 1'b1;
               if (settleEnd) begin
                  wd_r    <= WD_RUN;
                  wdCnt_r <= '0;
               end
            end
            WD_RUN: begin
               if (kickFall)
                  wdCnt_r <= '0;
               else if (wdHit) begin
                  wd_r    <= WD_FAULT;
                  wdCnt_r <= '0;
               end else
                  wdCnt_r <= wdCnt_r + 1'b1;
            end
            WD_FAULT: begin
               wdCnt_r <= wdCnt_r + 1'b1;
               if (faultEnd) begin
                  wd_r    <= WD_RUN;
                  wdCnt_r <= '0;
               end
            end
            default: begin
               wd_r <= WD_OFF;
            end
         endcase
      end
   end

endmodule // srwd_supervisor

// [sim/srwd_supervisor_chk.sv]
`timescale 1ns/1ps
module srwd_supervisor_chk
   import srwd_pkg::*;
#(
   parameter int RST_TICKS     = 50,
   parameter int INIT_TICKS    = 60,
   parameter int WD_PULL_TICKS = 100
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // watched pins
   input wire logic uvBelowThr,
   input wire logic manualResetInN,
   input wire logic wdKickIn,
   input wire logic wdEnableStrap,
   input wire logic timeoutConfigPinOe,
   input wire logic resetOutNOe,
   input wire logic wdFaultOutNOe,
   input wire logic probeDone
);
   logic [31:0] okCnt_r, fltCnt_r, idlCnt_r, prbCnt_r;
   logic        kickQ_r, oeQ_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // each counter restarts on the event it times from
   always_ff @(posedge sys_clk) begin
      kickQ_r  <= wdKickIn;
      oeQ_r    <= timeoutConfigPinOe;
      okCnt_r  <= (srst || uvBelowThr || !manualResetInN) ? 32'h0 : okCnt_r + 32'h1;
      fltCnt_r <= wdFaultOutNOe ? fltCnt_r + 32'h1 : 32'h0;
      idlCnt_r <= (resetOutNOe || wdFaultOutNOe || !probeDone || (kickQ_r && !wdKickIn))
                  ? 32'h0 : idlCnt_r + 32'h1;
      prbCnt_r <= (timeoutConfigPinOe && !oeQ_r) ? 32'h0 : prbCnt_r + 32'h1;
   end
   mr_assert_a: assert property ($fell(manualResetInN) |-> ##[1:4] resetOutNOe)
      else $error("manual reset not seen");
   uv_hold_a: assert property (uvBelowThr [*4] |-> resetOutNOe)
      else $error("undervoltage without reset");
   fault_off_a: assert property (resetOutNOe |-> !wdFaultOutNOe)
      else $error("fault driven during reset");
   release_wait_a: assert property ($fell(resetOutNOe) |->
      okCnt_r >= RST_TICKS && okCnt_r <= RST_TICKS + 6) else $error("release delay off");
   fault_len_a: assert property ($fell(wdFaultOutNOe) && !resetOutNOe && wdEnableStrap |->
      fltCnt_r >= RST_TICKS - 1 && fltCnt_r <= RST_TICKS + 1) else $error("fault length off");
   kick_min_a: assert property ($rose(wdFaultOutNOe) |-> idlCnt_r >= WD_PULL_TICKS)
      else $error("fault before timeout");
   probe_len_a: assert property ($rose(probeDone) |->
      prbCnt_r >= INIT_TICKS - 2 && prbCnt_r <= INIT_TICKS + 1) else $error("probe length off");
   probe_start_a: assert property ($fell(uvBelowThr) |-> ##[1:6] timeoutConfigPinOe)
      else $error("probe not restarted");
endmodule // srwd_supervisor_chk

bind srwd_supervisor srwd_supervisor_chk #(
   .RST_TICKS    (RST_TICKS),
   .INIT_TICKS   (INIT_TICKS),
   .WD_PULL_TICKS(WD_PULL_TICKS)
) i_chk (
   .sys_clk, .srst, .uvBelowThr, .manualResetInN, .wdKickIn, .wdEnableStrap,
   .timeoutConfigPinOe, .resetOutNOe, .wdFaultOutNOe, .probeDone
);

// [sim/srwd_host.sv]
`timescale 1ns/1ps
module srwd_host (
   // clock
   input  wire logic        sys_clk,
   // kick control
   input  wire logic        kickOn,
   input  wire logic [15:0] period,
   // kick pin
   output logic             wdKickIn
);
   logic [15:0] cnt_r = 16'h0;
   initial wdKickIn = 1'b1;
   always @(posedge sys_clk) begin
      cnt_r    <= (!kickOn || cnt_r >= period) ? 16'h0 : cnt_r + 16'h1;
      wdKickIn <= !(kickOn && cnt_r < 16'h2);
   end
endmodule // srwd_host

// [sim/srwd_supervisor_tb.sv]
`timescale 1ns/1ps
module srwd_supervisor_tb;
   import srwd_pkg::*;
   localparam int RT = 50;
   localparam int IT = 60;
   localparam int WO = 200;
   localparam int WP = 100;
   localparam int CT = 150;
   logic       sys_clk = 1'b0;
   logic       srst = 1'b1;
   logic       uvBelowThr = 1'b1;
   logic       manualResetInN = 1'b1;
   logic       wdEnableStrap = 1'b1;
   logic       kickOn = 1'b0;
   logic [1:0] pinMode = 2'h0;
   logic       wdKickIn, pinOe, pinLvl, rstOe, fltOe, probeDone;
   logic       rstO, fltO, pinO;
   srwd_cfg_e  cfgClass;
   srwd_cfg_e  modeTab [3] = '{CFG_PULLUP, CFG_CAP, CFG_OPEN};
   int         tmoTab [3] = '{WP, CT, WO};
   int         chg = 0;
   int         n_errors = 0;
   int         samples_checked = 0;
   int         n;

   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) chg <= pinOe ? 0 : chg + 1;
   // open pin sinks weakly low; capacitor climbs late
   assign pinLvl = !pinOe && (pinMode == 2'h1 || (pinMode == 2'h2 && chg > 12));

   srwd_supervisor #(
      .RST_TICKS(RT), .INIT_TICKS(IT), .WD_OPEN_TICKS(WO), .WD_PULL_TICKS(WP), .CAP_TICKS(CT)
   ) i_dut (
      .sys_clk, .srst, .uvBelowThr, .manualResetInN, .wdKickIn, .wdEnableStrap,
      .timeoutConfigPinI(pinLvl), .timeoutConfigPinO(pinO), .timeoutConfigPinOe(pinOe),
      .resetOutNO(rstO), .resetOutNOe(rstOe), .wdFaultOutNO(fltO), .wdFaultOutNOe(fltOe),
      .cfgClass, .probeDone
   );
   srwd_host i_host (.sys_clk, .kickOn, .period(16'h32), .wdKickIn);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic span(input int lo, input int hi);
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // s: 0 reset, 1 fault, 2 probe done
   task automatic waitLvl(input int s, input logic v, input int lim);
      n = 0;
      while ((s == 0 ? rstOe : s == 1 ? fltOe : probeDone) !== v && n < lim) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= lim) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic quiet(input int k);
      n = 0;
      repeat (k) begin
         @(posedge sys_clk);
         n += int'(fltOe !== 1'b0);
      end
      check(n, 32'h0);
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      uvBelowThr <= 1'b0;
      waitLvl(0, 1'b0, 400);
      span(RT, RT + 6);
      waitLvl(2, 1'b1, 400);
      check({30'h0, cfgClass}, {30'h0, CFG_OPEN});
      // 10 nF: 32.681 ms and 829 ms at 20 MHz
      check(32'(cap_ticks(10, 1'b0)), 32'h0009f934);
      check(32'(cap_ticks(10, 1'b1)), 32'h00fcfda0);
      $display("power-up done");
      @(posedge sys_clk);
      wdEnableStrap <= 1'b0;
      quiet(300);
      wdEnableStrap <= 1'b1;
      waitLvl(1, 1'b1, 4000);
      span(SETTLE_CYC + WO, SETTLE_CYC + WO + 8);
      waitLvl(1, 1'b0, 400);
      span(RT - 1, RT + 2);
      $display("strap test done");
      @(posedge sys_clk);
      kickOn <= 1'b1;
      quiet(1000);
      kickOn <= 1'b0;
      waitLvl(1, 1'b1, 400);
      span(WO - 60, WO + 8);
      $display("kick test done");
      @(posedge sys_clk);
      manualResetInN <= 1'b0;
      waitLvl(0, 1'b1, 20);
      span(1, 4);
      check({29'h0, rstO, fltO, pinO}, 32'h0);
      check({31'h0, fltOe}, 32'h0);
      @(posedge sys_clk);
      kickOn     <= 1'b1;
      uvBelowThr <= 1'b1;
      repeat (30) @(posedge sys_clk);
      manualResetInN <= 1'b1;
      repeat (100) @(posedge sys_clk);
      check({31'h0, rstOe}, 32'h1);
      kickOn <= 1'b0;
      $display("manual reset done");
      for (int i = 0; i < 3; i++) begin
         pinMode    <= modeTab[i];
         uvBelowThr <= 1'b1;
         repeat (25) @(posedge sys_clk);
         uvBelowThr <= 1'b0;
         waitLvl(0, 1'b0, 400);
         span(RT, RT + 6);
         waitLvl(2, 1'b1, 400);
         check({30'h0, cfgClass}, {30'h0, modeTab[i]});
         waitLvl(1, 1'b1, 400);
         span(tmoTab[i], tmoTab[i] + 4);
         @(posedge sys_clk);
      end
      $display("mode sweep done");
      summarize();
   end
endmodule // srwd_supervisor_tb
